// >>> rtl/i2c_rs_defs.svh
// Offsets, field positions and reset values of the repeated start block.
`ifndef I2C_RS_DEFS_SVH
`define I2C_RS_DEFS_SVH

// Register word offsets on the plain register port.
`define OFF_PORT_CONTROL     3'h0
`define OFF_MASTER_CTL_TWO   3'h1
`define OFF_PORT_STATUS      3'h2
`define OFF_RATE_RELOAD      3'h3
`define OFF_SHIFT_BUFFER     3'h4
`define OFF_EVENT_STATUS     3'h5
`define OFF_EVENT_MASK       3'h6

// Port control fields.
`define BIT_PORT_ENABLE      5

// Master control two fields.
`define BIT_START_REQ        0
`define BIT_REPEAT_START     1
`define BIT_STOP_REQ         2
`define BIT_RECEIVE_REQ      3
`define BIT_ACK_SEQ_REQ      4
`define CTL_TWO_LOW_MASK     5'h1f

// Port status fields.
`define BIT_BUFFER_FULL      0
`define BIT_XMIT_BUSY        2
`define BIT_START_SEEN       3
`define BIT_STOP_SEEN        4
`define BIT_PORT_IDLE        5

// Event status and mask fields.
`define BIT_EVT_PORT         0
`define BIT_EVT_COLLISION    1
`define BIT_EVT_CLASH        2

// Reset values.
`define RST_BYTE             8'h00
`define RST_RATE             7'h00
`define RST_EVENTS           3'h0

// Rate counter reload field top bit positions.
`define RATE_SHORT_MSB       5
`define RATE_LONG_MSB        6

`endif

// >>> rtl/i2c_rs_pkg.sv
// Types shared by the repeated start block.
package i2c_rs_pkg;

   // Sequence states, one-hot.
   typedef enum logic [5:0] {
      S_IDLE    = 6'h01,
      S_SCL_LOW = 6'h02,
      S_SDA_REL = 6'h04,
      S_SCL_REL = 6'h08,
      S_HOLD    = 6'h10,
      S_SDA_LOW = 6'h20
   } seq_state_t;

   // Synchroniser chain and previous sample of one bus line.
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } line_sample_t;

   // Whole state of the block.
   typedef struct packed {
      seq_state_t   fsm;
      line_sample_t scl;
      line_sample_t sda;
      logic [6:0]   cnt;
      logic         sclDrive;
      logic         sdaDrive;
      logic         portEnable;
      logic [4:0]   ctlTwo;
      logic [6:0]   rate;
      logic [7:0]   shiftBuffer;
      logic         bufferFull;
      logic         startSeen;
      logic         stopSeen;
      logic [2:0]   events;
      logic [2:0]   mask;
      logic [7:0]   rdData;
      logic         irq;
   } block_state_t;

endpackage

// >>> rtl/i2c_master_repeated_start.sv
// Master-side repeated start generator of a two-wire serial port with collision detection.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "i2c_rs_defs.svh"

// Operation
// - Repeat-start request when idle pulls SCL low
// - SCL low: load counter 5:0, release SDA
// - Timeout, SDA high: release SCL; SCL rise: reload 6:0
// - Both high one period, then SDA low
// - End: clear request, stop counter, hold SDA
// - Start seen at once; event after timeout
// - Request ignored while another event runs
// - Buffer write during sequence sets clash
// - Low control-two bits locked during sequence
// - SDA low at SCL rise is collision
// - SCL low before SDA asserted: collision
// - Count down, release SCL, check SDA
// - SDA fall during hold is no collision
// - SCL fall before timeout is collision
// - Timeout both high: SDA low, then SCL low
// - Buffer full set with byte, cleared empty
module i2c_master_repeated_start (
   input  wire logic       sys_clk,      // System clock, 20 MHz.
   input  wire logic       rst_n,        // Asynchronous reset, active low.
   input  wire logic [2:0] regAddr,      // Register word offset.
   input  wire logic [7:0] regWrData,    // Register write data.
   input  wire logic       regWrStb,     // One-cycle write strobe.
   input  wire logic       regRdStb,     // One-cycle read strobe.
   output logic      [7:0] regRdData,    // Read data, valid the cycle after the strobe.
   input  wire logic       sclIn,        // Level of the clock line.
   output logic            sclOut,       // Clock line drive level, always low.
   output logic            sclOen,       // Clock line enable, low while pulling low.
   input  wire logic       sdaIn,        // Level of the data line.
   output logic            sdaOut,       // Data line drive level, always low.
   output logic            sdaOen,       // Data line enable, low while pulling low.
   output logic            irq           // Level interrupt, high while an unmasked event is set.
);

   ////////////////////////////////////////////////////////////////////////////////
   // State registers.
   ////////////////////////////////////////////////////////////////////////////////

   i2c_rs_pkg::block_state_t st_reg;     // Registered state of the block.
   i2c_rs_pkg::block_state_t st_next;    // Next value of the state.
   logic                     sequenceOn; // High while a repeated start is being generated.
   logic                     collision;  // One-cycle pulse on a detected collision.

   // Read multiplexer shared by the read path.
   function automatic logic [7:0] readWord(input i2c_rs_pkg::block_state_t s,
                                           input logic [2:0] a);
      logic [7:0] w;
      w = 8'h00;
      case (a)
         `OFF_PORT_CONTROL: begin
            w[`BIT_PORT_ENABLE] = s.portEnable;
         end
         `OFF_MASTER_CTL_TWO: begin
            w[4:0] = s.ctlTwo;
         end
         `OFF_PORT_STATUS: begin
            w[`BIT_BUFFER_FULL] = s.bufferFull;
            w[`BIT_XMIT_BUSY]   = s.bufferFull;
            w[`BIT_START_SEEN]  = s.startSeen;
            w[`BIT_STOP_SEEN]   = s.stopSeen;
            w[`BIT_PORT_IDLE]   = ~(s.bufferFull | (|s.ctlTwo));
         end
         `OFF_RATE_RELOAD: begin
            w[6:0] = s.rate;
         end
         `OFF_SHIFT_BUFFER: begin
            w = s.shiftBuffer;
         end
         `OFF_EVENT_STATUS: begin
            w[2:0] = s.events;
         end
         `OFF_EVENT_MASK: begin
            w[2:0] = s.mask;
         end
         default: begin
            w = 8'h00;
         end
      endcase
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   ////////////////////////////////////////////////////////////////////////////////

   // Computes the sequence, the line drives, the flags and the register writes.
   always_comb begin
      logic expired;
      logic sclRise;
      logic sclFall;
      logic eventDone;
      logic clash;
      logic wrCtl;
      logic wrCtlTwo;
      logic wrBuf;
      logic wrEvt;
      logic otherBusy;
      expired   = 1'b0;
      sclRise   = 1'b0;
      sclFall   = 1'b0;
      eventDone = 1'b0;
      clash     = 1'b0;
      collision = 1'b0;
      // Strobe decodes and the busy term start defined on every pass.
      wrCtl     = 1'b0;
      wrCtlTwo  = 1'b0;
      wrBuf     = 1'b0;
      wrEvt     = 1'b0;
      otherBusy = 1'b0;
      st_next   = st_reg;
      // Two-stage synchronisers; only the second stage and its delayed copy are looked at.
      st_next.scl.meta = sclIn;
      st_next.scl.sync = st_reg.scl.meta;
      st_next.scl.prev = st_reg.scl.sync;
      st_next.sda.meta = sdaIn;
      st_next.sda.sync = st_reg.sda.meta;
      st_next.sda.prev = st_reg.sda.sync;
      sclRise = st_reg.scl.sync & ~st_reg.scl.prev;
      sclFall = ~st_reg.scl.sync & st_reg.scl.prev;
      sequenceOn = (st_reg.fsm != i2c_rs_pkg::S_IDLE);
      wrCtl    = regWrStb && (regAddr == `OFF_PORT_CONTROL);
      wrCtlTwo = regWrStb && (regAddr == `OFF_MASTER_CTL_TWO);
      wrBuf    = regWrStb && (regAddr == `OFF_SHIFT_BUFFER);
      wrEvt    = regWrStb && (regAddr == `OFF_EVENT_STATUS);
      otherBusy = st_reg.bufferFull | st_reg.ctlTwo[`BIT_START_REQ]
                | st_reg.ctlTwo[`BIT_STOP_REQ] | st_reg.ctlTwo[`BIT_RECEIVE_REQ]
                | st_reg.ctlTwo[`BIT_ACK_SEQ_REQ];

      // The rate counter counts down one step per system clock and stops at zero.
      if (st_reg.cnt != 7'h00) begin
         st_next.cnt = st_reg.cnt - 7'h01;
      end else begin
         expired = 1'b1;
      end

      // Start and stop conditions seen on the bus, by anybody.
      if (st_reg.sda.prev && !st_reg.sda.sync && st_reg.scl.sync && st_reg.scl.prev) begin
         st_next.startSeen = 1'b1;
         st_next.stopSeen  = 1'b0;
      end else if (!st_reg.sda.prev && st_reg.sda.sync && st_reg.scl.sync
                   && st_reg.scl.prev) begin
         st_next.stopSeen  = 1'b1;
         st_next.startSeen = 1'b0;
      end

      // Repeated start sequencer.
      case (st_reg.fsm)
         i2c_rs_pkg::S_IDLE: begin
            // A request that was accepted opens the sequence by pulling SCL low.
            if (st_reg.ctlTwo[`BIT_REPEAT_START]) begin
               st_next.sclDrive = 1'b1;
               st_next.fsm      = i2c_rs_pkg::S_SCL_LOW;
            end
         end
         i2c_rs_pkg::S_SCL_LOW: begin
            // Once SCL reads low, SDA is let go for the short rate period.
            if (!st_reg.scl.sync) begin
               st_next.cnt      = {1'b0, st_reg.rate[`RATE_SHORT_MSB:0]};
               st_next.sdaDrive = 1'b0;
               st_next.fsm      = i2c_rs_pkg::S_SDA_REL;
            end
         end
         i2c_rs_pkg::S_SDA_REL: begin
            // At timeout SDA must read high before SCL may be released.
            if (expired) begin
               if (st_reg.sda.sync) begin
                  st_next.sclDrive = 1'b0;
                  st_next.fsm      = i2c_rs_pkg::S_SCL_REL;
               end else begin
                  collision = 1'b1;
               end
            end
         end
         i2c_rs_pkg::S_SCL_REL: begin
            // SDA is checked at the moment SCL is seen rising.
            // A low SDA here means a rival master is sending a zero.
            if (sclRise) begin
               if (!st_reg.sda.sync) begin
                  collision = 1'b1;
               end else begin
                  st_next.cnt = st_reg.rate;
                  st_next.fsm = i2c_rs_pkg::S_HOLD;
               end
            end
         end
         i2c_rs_pkg::S_HOLD: begin
            // SCL dropping here means another master is sending a one.
            // SDA dropping is tolerated, as two masters never assert it together.
            if (sclFall) begin
               collision = 1'b1;
            end else if (expired) begin
               st_next.sdaDrive = 1'b1;
               st_next.cnt      = st_reg.rate;
               st_next.fsm      = i2c_rs_pkg::S_SDA_LOW;
            end
         end
         i2c_rs_pkg::S_SDA_LOW: begin
            // SCL is pulled low at timeout whatever its level; SDA stays held low.
            if (expired) begin
               st_next.sclDrive = 1'b1;
               st_next.ctlTwo[`BIT_REPEAT_START] = 1'b0;
               eventDone   = 1'b1;
               st_next.fsm = i2c_rs_pkg::S_IDLE;
            end
         end
         default: begin
            st_next.fsm = i2c_rs_pkg::S_IDLE;
         end
      endcase

      // A collision abandons the sequence and frees both lines.
      if (collision) begin
         st_next.sclDrive = 1'b0;
         st_next.sdaDrive = 1'b0;
         st_next.ctlTwo[`BIT_REPEAT_START] = 1'b0;
         st_next.cnt = 7'h00;
         st_next.fsm = i2c_rs_pkg::S_IDLE;
      end

      // Register writes.
      if (wrCtl) begin
         st_next.portEnable = regWrData[`BIT_PORT_ENABLE];
      end
      if (wrCtlTwo && !sequenceOn && !st_reg.ctlTwo[`BIT_REPEAT_START]) begin
         // The low bits are locked while a repeated start is pending or running.
         st_next.ctlTwo = regWrData[4:0] & `CTL_TWO_LOW_MASK;
         if (otherBusy || !st_reg.portEnable) begin
            // A repeat-start request over another pending event does not take effect.
            st_next.ctlTwo[`BIT_REPEAT_START] = 1'b0;
         end
      end
      if (regWrStb && (regAddr == `OFF_RATE_RELOAD)) begin
         st_next.rate = regWrData[6:0];
      end
      if (wrBuf) begin
         if (sequenceOn || st_reg.ctlTwo[`BIT_REPEAT_START]) begin
            clash = 1'b1;
         end else begin
            st_next.shiftBuffer = regWrData;
            st_next.bufferFull  = 1'b1;
         end
      end
      if (regRdStb && (regAddr == `OFF_SHIFT_BUFFER)) begin
         st_next.bufferFull = 1'b0;
      end
      if (regWrStb && (regAddr == `OFF_EVENT_MASK)) begin
         st_next.mask = regWrData[2:0];
      end

      // Sticky events: writing one clears, a new event in the same cycle wins.
      st_next.events = st_reg.events & ~(wrEvt ? regWrData[2:0] : 3'h0);
      st_next.events[`BIT_EVT_PORT]      = st_next.events[`BIT_EVT_PORT] | eventDone;
      st_next.events[`BIT_EVT_COLLISION] = st_next.events[`BIT_EVT_COLLISION] | collision;
      st_next.events[`BIT_EVT_CLASH]     = st_next.events[`BIT_EVT_CLASH] | clash;

      // A disabled port frees the lines and forgets bus conditions.
      if (!st_reg.portEnable) begin
         st_next.fsm       = i2c_rs_pkg::S_IDLE;
         st_next.sclDrive  = 1'b0;
         st_next.sdaDrive  = 1'b0;
         st_next.startSeen = 1'b0;
         st_next.stopSeen  = 1'b0;
         st_next.ctlTwo[`BIT_REPEAT_START] = 1'b0;
      end

      st_next.rdData = regRdStb ? readWord(st_reg, regAddr) : 8'h00;
      st_next.irq    = |(st_next.events & st_next.mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State flip-flops.
   ////////////////////////////////////////////////////////////////////////////////

   // Registers the whole state; reset puts every field at a constant.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg             <= '0;
         st_reg.fsm         <= i2c_rs_pkg::S_IDLE;
         st_reg.scl         <= 3'h7;
         st_reg.sda         <= 3'h7;
         st_reg.ctlTwo      <= 5'h00;
         st_reg.rate        <= `RST_RATE;
         st_reg.shiftBuffer <= `RST_BYTE;
         st_reg.events      <= `RST_EVENTS;
         st_reg.mask        <= `RST_EVENTS;
         st_reg.rdData      <= `RST_BYTE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops; the lines are open drain and only ever pulled low.
   // The enables are inverted drive flags, so both lines read released from reset on.
   assign sclOut    = 1'b0 & st_reg.sclDrive;
   assign sdaOut    = 1'b0 & st_reg.sdaDrive;
   assign sclOen    = ~st_reg.sclDrive;
   assign sdaOen    = ~st_reg.sdaDrive;
   assign regRdData = st_reg.rdData;
   assign irq       = st_reg.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   ////////////////////////////////////////////////////////////////////////////////

   // Every property below samples on the system clock and is cut off while reset is low.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_scl_first_low: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_IDLE && st_reg.ctlTwo[`BIT_REPEAT_START]
       && st_reg.portEnable) |=> (!sclOen && st_reg.fsm == i2c_rs_pkg::S_SCL_LOW))
      else $error("repeat start did not pull SCL low");

   a_sda_release_load: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_SCL_LOW && !st_reg.scl.sync && st_reg.portEnable)
      |=> (sdaOen && st_reg.cnt == {1'b0, $past(st_reg.rate[5:0])}))
      else $error("SDA not released with short reload");

   a_scl_release: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_SDA_REL && st_reg.cnt == 7'h00 && st_reg.sda.sync
       && st_reg.portEnable) |=> sclOen)
      else $error("SCL not released at timeout");

   a_sda_assert_hold: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_HOLD && st_reg.cnt == 7'h00 && st_reg.scl.sync
       && st_reg.scl.prev && st_reg.portEnable) |=> (!sdaOen && sclOen))
      else $error("SDA not driven low after hold");

   a_sequence_end: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_SDA_LOW && st_reg.cnt == 7'h00 && st_reg.portEnable)
      |=> (!st_reg.ctlTwo[`BIT_REPEAT_START] && !sdaOen && !sclOen
           && st_reg.events[`BIT_EVT_PORT]))
      else $error("sequence end wrong");

   a_event_after_timeout: assert property (
      $rose(st_reg.events[`BIT_EVT_PORT]) |-> ($past(st_reg.fsm) == i2c_rs_pkg::S_SDA_LOW))
      else $error("event flag raised early");

   a_ignore_busy: assert property (
      (regWrStb && regAddr == `OFF_MASTER_CTL_TWO && st_reg.bufferFull)
      |=> !st_reg.ctlTwo[`BIT_REPEAT_START] ##1 st_reg.fsm == i2c_rs_pkg::S_IDLE)
      else $error("request accepted while busy");

   a_clash_keep: assert property (
      (regWrStb && regAddr == `OFF_SHIFT_BUFFER && sequenceOn)
      |=> (st_reg.events[`BIT_EVT_CLASH] && $stable(st_reg.shiftBuffer)))
      else $error("buffer write during sequence not refused");

   a_ctl_locked: assert property (
      (regWrStb && regAddr == `OFF_MASTER_CTL_TWO && sequenceOn)
      |=> (st_reg.ctlTwo[4:2] == $past(st_reg.ctlTwo[4:2])
           && st_reg.ctlTwo[0] == $past(st_reg.ctlTwo[0])))
      else $error("control bits changed during sequence");

   a_hold_collide: assert property (
      (st_reg.fsm == i2c_rs_pkg::S_HOLD && !st_reg.scl.sync && st_reg.scl.prev)
      |-> collision)
      else $error("SCL fall during hold not a collision");

   a_abort_release: assert property (
      collision |=> (sclOen && sdaOen && st_reg.fsm == i2c_rs_pkg::S_IDLE
                     && st_reg.events[`BIT_EVT_COLLISION]))
      else $error("collision did not abort");

endmodule // i2c_master_repeated_start

// >>> sim/i2c_bus_model.sv
// Far side of the two-wire bus: pull-ups plus a rival master that can hold lines low.
`timescale 1ns/10ps
module i2c_bus_model (
   input  wire logic       sys_clk,  // System clock.
   input  wire logic       rst_n,    // Reset, active low.
   input  wire logic       sclOen,   // Block clock line enable, low pulls down.
   input  wire logic       sdaOen,   // Block data line enable, low pulls down.
   input  wire logic [1:0] mode,     // 0 quiet, 1 data held low, 2 clock pulled, 3 rival zero.
   output logic            sclLine,  // Resolved clock line.
   output logic            sdaLine   // Resolved data line.
);
   logic [3:0] relCnt;    // Cycles since the block released the clock line.
   logic       rivalScl;  // Rival master pulls the clock line low.

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Count from the block's clock release, so the rival strikes inside the hold period.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         relCnt <= 4'h0;
      end else if (!sclOen) begin
         relCnt <= 4'h0;
      end else if (relCnt != 4'hf) begin
         relCnt <= relCnt + 4'h1;
      end
   end

   // A rival sending a one drops the clock before the block drives data low.
   assign rivalScl = (mode == 2'h2) && (relCnt >= 4'h6) && (relCnt <= 4'hb);
   // Both lines have pull-ups, so a released line reads high.
   assign sclLine = sclOen & ~rivalScl;
   // Mode 1 holds data low throughout; mode 3 drops data as the block lets the clock go.
   assign sdaLine = sdaOen & ~(mode == 2'h1) & ~((mode == 2'h3) & sclOen);
endmodule // i2c_bus_model

// >>> sim/i2c_master_repeated_start_bench.sv
// Self-checking bench of the repeated start block against the bus model.
`timescale 1ns/10ps
`include "i2c_rs_defs.svh"
module i2c_master_repeated_start_bench;
   logic       sys_clk;       // System clock, 50 ns.
   logic       rst_n;         // Reset, active low.
   logic [2:0] regAddr;       // Register offset.
   logic [7:0] regWrData;     // Write data.
   logic       regWrStb;      // Write strobe.
   logic       regRdStb;      // Read strobe.
   logic [7:0] regRdData;     // Read data.
   logic       sclLine;       // Resolved clock line.
   logic       sdaLine;       // Resolved data line.
   logic       sclOen;        // Block clock enable.
   logic       sdaOen;        // Block data enable.
   logic       irq;           // Interrupt.
   logic       sclOut;        // Block clock drive level.
   logic       sdaOut;        // Block data drive level.
   logic [1:0] mode;          // Bus model behaviour.
   logic [7:0] rd;            // Last read value.
   int         err_count;     // Mismatches.
   int         total_checks;  // Comparisons.
   int         n;             // Cycles waited.

   i2c_master_repeated_start uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .sclIn(sclLine),
      .sclOut(sclOut), .sclOen(sclOen), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOen(sdaOen),
      .irq(irq));

   i2c_bus_model bus (
      .sys_clk(sys_clk), .rst_n(rst_n), .sclOen(sclOen), .sdaOen(sdaOen), .mode(mode),
      .sclLine(sclLine), .sdaLine(sdaLine));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock generator.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle register write.
   task automatic regWr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge sys_clk);
      regWrStb  <= 1'b0;
   endtask

   // One-cycle register read; data is taken in the cycle after the strobe.
   task automatic regRd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 d = regRdData;
   endtask

   // Waits for a pair of line enables, counting cycles; a timeout ends the run.
   task automatic waitLines(input logic scl, input logic sda, output int cnt);
      for (cnt = 1; cnt < 400; cnt++) begin
         @(posedge sys_clk);
         #1;
         if (sclOen === scl && sdaOen === sda) return;
      end
      err_count++;
      tally_and_finish();
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values and an unmapped offset.
   task automatic resetValues();
      regRd(`OFF_PORT_STATUS, rd);
      check(rd, 8'h20);
      regRd(`OFF_MASTER_CTL_TWO, rd);
      check(rd, 8'h00);
      regRd(`OFF_EVENT_STATUS, rd);
      check(rd, 8'h00);
      regRd(3'h7, rd);
      check(rd, 8'h00);
   endtask

   // Full sequence with a blocked buffer write and a blocked control write.
   task automatic normalSequence();
      regWr(`OFF_PORT_CONTROL, 8'h20);
      regWr(`OFF_RATE_RELOAD, 8'h08);
      regWr(`OFF_MASTER_CTL_TWO, 8'h02);
      regWr(`OFF_SHIFT_BUFFER, 8'h55);
      regWr(`OFF_MASTER_CTL_TWO, 8'h04);
      // Each phase lasts rate+1 cycles; a line seen through the two sync flops adds three.
      waitLines(1'b0, 1'b1, n);
      check(n[7:0], 8'h01);
      waitLines(1'b1, 1'b1, n);
      check(n[7:0], 8'h08);
      waitLines(1'b1, 1'b0, n);
      check(n[7:0], 8'h0c);
      waitLines(1'b0, 1'b0, n);
      check(n[7:0], 8'h09);
      repeat (4) @(posedge sys_clk);
      #1 check({4'h0, sclOut, sdaOut, sclOen, sdaOen}, 8'h00);
      regRd(`OFF_MASTER_CTL_TWO, rd);
      check(rd, 8'h00);
      regRd(`OFF_SHIFT_BUFFER, rd);
      check(rd, 8'h00);
      regRd(`OFF_EVENT_STATUS, rd);
      check(rd, 8'h05);
      regWr(`OFF_SHIFT_BUFFER, 8'ha0);
      regRd(`OFF_SHIFT_BUFFER, rd);
      check(rd, 8'ha0);
      regRd(`OFF_PORT_STATUS, rd);
      check(rd & 8'h29, 8'h28);
      check({7'h0, irq}, 8'h00);
      regWr(`OFF_EVENT_MASK, 8'h01);
      @(posedge sys_clk);
      #1 check({7'h0, irq}, 8'h01);
      regWr(`OFF_EVENT_STATUS, 8'h07);
      @(posedge sys_clk);
      #1 check({7'h0, irq}, 8'h00);
      regWr(`OFF_PORT_CONTROL, 8'h00);
      regWr(`OFF_PORT_CONTROL, 8'h20);
      #1 check({6'h0, sclOen, sdaOen}, 8'h03);
   endtask

   // A request while the buffer is busy is dropped; a buffer read empties it.
   task automatic refusedRequest();
      regWr(`OFF_SHIFT_BUFFER, 8'ha5);
      regRd(`OFF_PORT_STATUS, rd);
      check(rd & 8'h25, 8'h05);
      regWr(`OFF_MASTER_CTL_TWO, 8'h02);
      repeat (6) @(posedge sys_clk);
      #1 check({7'h0, sclOen}, 8'h01);
      regRd(`OFF_MASTER_CTL_TWO, rd);
      check(rd, 8'h00);
      regRd(`OFF_SHIFT_BUFFER, rd);
      check(rd, 8'ha5);
      regRd(`OFF_PORT_STATUS, rd);
      check(rd & 8'h21, 8'h20);
   endtask

   // A rival master forces a collision; the block must abandon and release.
   task automatic collision(input logic [1:0] m);
      mode <= m;
      repeat (20) @(posedge sys_clk);
      regWr(`OFF_RATE_RELOAD, 8'h14);
      regWr(`OFF_MASTER_CTL_TWO, 8'h02);
      for (n = 0; n < 60 && rd[1] !== 1'b1; n++) begin
         regRd(`OFF_EVENT_STATUS, rd);
      end
      if (rd[1] !== 1'b1) begin
         err_count++;
         tally_and_finish();
      end
      check(rd & 8'h03, 8'h02);
      check({6'h0, sclOen, sdaOen}, 8'h03);
      regRd(`OFF_MASTER_CTL_TWO, rd);
      check(rd, 8'h00);
      mode <= 2'h0;
      regWr(`OFF_EVENT_STATUS, 8'h07);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      err_count    = 0;
      total_checks = 0;
      rst_n        = 1'b0;
      regAddr      = 3'h0;
      regWrData    = 8'h00;
      regWrStb     = 1'b0;
      regRdStb     = 1'b0;
      mode         = 2'h0;
      rd           = 8'h00;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      resetValues();
      normalSequence();
      refusedRequest();
      collision(2'h1);
      collision(2'h2);
      collision(2'h3);
      tally_and_finish();
   end
endmodule // i2c_master_repeated_start_bench
